// ### dv/ocdmc_assertions.sv
// checker: port properties of debug mode control
`timescale 1ns/1ps
module ocdmc_assertions
    import ocdmc_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  extResetPin_n,
    input wire logic                  internalReset,
    input wire logic                  debugUnitResetPin,
    input wire logic                  cpuAtBreak,
    input wire ocdmc_pkg::ocdmc_ctl_t ctl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_brk; (cpuAtBreak && !internalReset)[*6]; endsequence
    sequence s_pin; (!extResetPin_n && !cpuAtBreak)[*4]; endsequence
    property p_off; (!debugUnitResetPin)[*4] |-> !ctl.debugPinsEn; endproperty
    a_off: assert property (p_off) else $error("pins on");
    property p_rise; $rose(ctl.debugPinsEn) |-> $past(debugUnitResetPin, 3); endproperty
    a_rise: assert property (p_rise) else $error("bad rise");
    property p_ddo; ctl.debugPinsEn |-> ctl.ddoOut && ctl.ddoOe; endproperty
    a_ddo: assert property (p_ddo) else $error("ddo");
    property p_reg; ctl.debugPinsEn |-> ctl.regNormalHold && !ctl.lowVoltAllow; endproperty
    a_reg: assert property (p_reg) else $error("regulator");
    property p_brk; s_brk |-> !ctl.cpuResetReq && !ctl.periphResetReq; endproperty
    a_brk: assert property (p_brk) else $error("break reset");
    property p_buf; (!extResetPin_n)[*4] |-> ##[0:3] ctl.portBufResetReq; endproperty
    a_buf: assert property (p_buf) else $error("port buffers");
    property p_pin; s_pin |-> ##[0:3] ctl.cpuResetReq; endproperty
    a_pin: assert property (p_pin) else $error("pin reset");
    property p_int; internalReset[*3] |-> ##[0:3] ctl.periphResetReq; endproperty
    a_int: assert property (p_int) else $error("internal reset");
endmodule
bind ocdmc_top ocdmc_assertions u_chk (.clk(clk), .rst_n(rst_n), .extResetPin_n(extResetPin_n),
    .internalReset(internalReset), .debugUnitResetPin(debugUnitResetPin), .cpuAtBreak(cpuAtBreak), .ctl(ctl));

// ### dv/ocdmc_emu.sv
// emulator model: debug reset, system reset and break pins
`timescale 1ns/1ps
module ocdmc_emu (
    input  wire logic clk,
    output logic      debug_unit_reset_pin,
    output logic      sysRst_n,
    output logic      brk
);
    initial {debug_unit_reset_pin, sysRst_n, brk} = 3'b010;
    task automatic setPins(input logic [2:0] p);
        @(posedge clk) {debug_unit_reset_pin, sysRst_n, brk} <= p;
    endtask
endmodule

// ### dv/tb_top.sv
// testbench: debug mode control scenarios
`timescale 1ns/1ps
module tb_top;
    import ocdmc_pkg::*;
    logic       clk, rst_n, intRst, debug_unit_reset_pin, sysRst_n, brk;
    ocdmc_req_t req;
    ocdmc_ctl_t ctl;
    logic [7:0] rdata;
    int         err_total = 0;
    int         n_compared = 0;
    ocdmc_top u_dut (.clk(clk), .rst_n(rst_n), .extResetPin_n(sysRst_n), .internalReset(intRst),
        .debugUnitResetPin(debug_unit_reset_pin), .cpuAtBreak(brk), .useDedicatedDebugUnit(1'b0), .lowVoltReq(1'b1),
        .req(req), .rdata(rdata), .ctl(ctl));
    ocdmc_emu u_emu (.clk(clk), .debug_unit_reset_pin(debug_unit_reset_pin), .sysRst_n(sysRst_n), .brk(brk));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe; idle cycle after keeps unlock armed
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) req <= '0;
        #1 chk(rdata, exp);
    endtask
    // two sync stages plus output register, with margin
    task automatic pins(input logic [2:0] p);
        u_emu.setPins(p);
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic t_mode;
        rd(OFF_DBG_MODE, 8'h01);
        pins(3'b110);
        chk(ctl & 8'hF8, 8'hF0);
        wr(OFF_PROTECT, PROTECT_KEY);
        wr(OFF_DBG_MODE, 8'h00);
        rd(OFF_DBG_MODE, 8'h01);
        pins(3'b010);
        chk(ctl & 8'h98, 8'h08);
        wr(OFF_DBG_MODE, 8'h00);
        rd(OFF_DBG_MODE, 8'h01);
        wr(OFF_PROTECT, PROTECT_KEY);
        wr(OFF_DBG_MODE, 8'h00);
        rd(OFF_DBG_MODE, 8'h00);
        pins(3'b110);
        chk(ctl & 8'h80, 8'h00);
        $display("mode test done");
    endtask
    task automatic t_rst;
        @(posedge clk) intRst <= 1'b1;
        pins(3'b010);
        chk(ctl & 8'h06, 8'h06);
        @(posedge clk) intRst <= 1'b0;
        rd(OFF_DBG_MODE, 8'h00);
        pins(3'b001);
        chk(ctl & 8'h07, 8'h01);
        pins(3'b000);
        chk(ctl & 8'h07, 8'h07);
        pins(3'b010);
        rd(OFF_DBG_MODE, 8'h01);
        $display("reset test done");
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {rst_n, intRst} = 2'b00;
        req = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_mode;
        t_rst;
        results;
    end
    initial begin
        #50000;
        err_total++;
        results;
    end
endmodule

// ### logic/ocdmc_pkg.sv
// package: constants and carrier types for the on-chip debug mode control block
package ocdmc_pkg;

    // debug mode register reset value and field position
    localparam logic [7:0] DBG_MODE_RESET    = 8'h01;
    localparam int         DBG_MODE_SEL_BIT  = 0;
    // register port offsets (byte addresses)
    localparam logic [3:0] OFF_DBG_MODE      = 4'h0;
    localparam logic [3:0] OFF_STATUS        = 4'h4;
    // protected write sequence key
    localparam logic [7:0] PROTECT_KEY       = 8'hA5;
    localparam logic [3:0] OFF_PROTECT       = 4'h8;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ocdmc_req_t;

    typedef struct packed {
        logic debugPinsEn;
        logic ddoOut;
        logic ddoOe;
        logic regNormalHold;
        logic lowVoltAllow;
        logic cpuResetReq;
        logic periphResetReq;
        logic portBufResetReq;
    } ocdmc_ctl_t;

endpackage

// ### logic/ocdmc_sync2.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ocdmc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ocdmc_sync_t;

    ocdmc_sync_t st_ff;
    ocdmc_sync_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = din;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.sync;
endmodule

// ### logic/ocdmc_top.sv
// on-chip debug mode control: pin enable, reset masking, forced pins and regulator
// Operation
// RULE1 - debug pins only when select=1 and dbg-reset high
// RULE2 - mode writes need dbg-reset low, protected sequence
// RULE3 - pin reset loads 01h; internal resets keep
// RULE4 - pin reset ignored during debug break
// RULE5 - masked pin reset still resets port buffers
// RULE6 - debug mode forces serial out pin high
// RULE7 - debug mode keeps regulator at normal voltage
// RULE8 - monitor debug masks only pin reset
// RULE9 - reset while running may disturb breaks
// RULE10 - software holds dbg-reset low or clears select
// RULE11 - monitor receive interrupt never masked
// RULE12 - monitor serial channel not reconfigured
// RULE13 - monitor receive vector location left free
// RULE14 - ten-byte security id in flash
// RULE15 - monitor flash area stays erased
// RULE16 - reset vector patterns limited for download
// RULE17 - port4 selections kept for clocked channel
// RULE18 - handshake port read-modify-write tolerates interrupts
// RULE19 - reset during live flash access unreliable
// RULE20 - registered debug pins enable signal
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module ocdmc_top
    import ocdmc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  extResetPin_n,
    input  wire logic                  internalReset,
    input  wire logic                  debugUnitResetPin,
    input  wire logic                  cpuAtBreak,
    input  wire logic                  useDedicatedDebugUnit,
    input  wire logic                  lowVoltReq,
    input  wire ocdmc_pkg::ocdmc_req_t req,
    output logic [7:0]                 rdata,
    output ocdmc_pkg::ocdmc_ctl_t      ctl
);
    import ocdmc_pkg::*;

    typedef struct packed {
        logic       modeSel;
        logic       unlocked;
        logic [7:0] rdata;
        ocdmc_ctl_t ctl;
    } ocdmc_state_t;

    ocdmc_state_t st_ff;
    ocdmc_state_t nxt_st;
    logic [2:0]   pinSync;
    logic         drstHigh;
    logic         pinRstAct;
    logic         breakSync;

    // pins cross into clk domain before use
    ocdmc_sync2 #(
        .W(3)
    ) u_sync (
        .clk  (clk),
        .rst_n(rst_n),
        .din  ({debugUnitResetPin, ~extResetPin_n, cpuAtBreak}),
        .dout (pinSync)
    );

    assign drstHigh  = pinSync[2];
    assign pinRstAct = pinSync[1];
    assign breakSync = pinSync[0];

    always_comb begin
        logic masked;
        logic debugMode;
        masked     = 1'b0;
        debugMode  = 1'b0;
        nxt_st     = st_ff;
        // RULE4 RULE8 break masks pin reset only
        masked = breakSync;
        // RULE2 key write arms one following write
        if (req.wr && req.addr == OFF_PROTECT) begin
            nxt_st.unlocked = (req.wdata == PROTECT_KEY);
        end else if (req.wr) begin
            nxt_st.unlocked = 1'b0;
        end
        // RULE2 mode write gated by dbg-reset low
        if (req.wr && req.addr == OFF_DBG_MODE && st_ff.unlocked && !drstHigh) begin
            nxt_st.modeSel = req.wdata[DBG_MODE_SEL_BIT];
        end
        // RULE3 pin reset reloads; internal resets keep
        // level, not edge: a reset held past the break end still reloads
        if (pinRstAct && !masked) begin
            nxt_st.modeSel = DBG_MODE_RESET[DBG_MODE_SEL_BIT];
        end
        // RULE1 RULE20 registered enable for pin mux
        debugMode = st_ff.modeSel & drstHigh;
        nxt_st.ctl.debugPinsEn = debugMode;
        // RULE6 serial out forced high
        nxt_st.ctl.ddoOut = debugMode;
        nxt_st.ctl.ddoOe  = debugMode;
        // RULE7 regulator stays normal in debug mode
        nxt_st.ctl.regNormalHold = debugMode;
        nxt_st.ctl.lowVoltAllow  = lowVoltReq & ~debugMode;
        // RULE9 RULE19 resets while running pass unguarded
        // RULE18 no port state kept here; monitor owns it
        // RULE4 no cpu/peripheral reset from pin at break; internal reset still passes
        nxt_st.ctl.cpuResetReq    = (pinRstAct & ~masked) | internalReset;
        nxt_st.ctl.periphResetReq = (pinRstAct & ~masked) | internalReset;
        // RULE5 port buffers still see pin reset
        nxt_st.ctl.portBufResetReq = pinRstAct;
        nxt_st.rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                OFF_DBG_MODE: nxt_st.rdata = {7'h00, st_ff.modeSel};
                OFF_STATUS:   nxt_st.rdata = {3'h0, useDedicatedDebugUnit, breakSync, drstHigh,
                                              st_ff.unlocked, debugMode};
                default:      nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff         <= '0;
            st_ff.modeSel <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;
    assign ctl   = st_ff.ctl;
endmodule
